//--- common/spm_pkg.sv
package spm_pkg;
	// ----------------------------------------
	// Register map (printed offsets are indices)
	// ----------------------------------------
	localparam logic [11:0] MON_ZERO_SELECT_IDX = 12'h230;
	localparam logic [11:0] MON_ONE_SELECT_IDX = 12'h231;
	localparam logic [11:0] MON_PIN_CONTROL_IDX = 12'h232;
	localparam logic [7:0] SELECT_RESET = 8'h00;
	localparam logic [7:0] PIN_CONTROL_RESET = 8'h00;
	localparam int SEL_W = 6;
	localparam int CTL_SYNC_BIT = 0;
	localparam int CTL_DIV0_BIT = 2;
	localparam int CTL_DIV1_BIT = 3;
	localparam int CTL_NVM_BIT = 4;
	localparam logic [7:0] CTL_WRITE_MASK = 8'h1d;
	// ----------------------------------------
	// Selection codes
	// ----------------------------------------
	localparam logic [5:0] SEL_GND = 6'h00;
	localparam logic [5:0] SEL_BOTH_LOCK = 6'h01;
	localparam logic [5:0] SEL_LOOP1_LOCK = 6'h02;
	localparam logic [5:0] SEL_LOOP2_LOCK = 6'h03;
	localparam logic [5:0] SEL_REFS_GONE = 6'h04;
	localparam logic [5:0] SEL_REFS_GONE_L2 = 6'h05;
	localparam logic [5:0] SEL_REFERENCE_B_CHOSEN = 6'h06;
	localparam logic [5:0] SEL_REFERENCE_A_OK = 6'h07;
	localparam logic [5:0] SEL_REFERENCE_B_OK = 6'h08;
	localparam logic [5:0] SEL_TEST_OK = 6'h09;
	localparam logic [5:0] SEL_OSC_OK = 6'h0a;
	localparam logic [5:0] SEL_L1FB_OK = 6'h0b;
	localparam logic [5:0] SEL_L2REF_OK = 6'h0c;
	localparam logic [5:0] SEL_RESV13 = 6'h0d;
	localparam logic [5:0] SEL_AB_OK = 6'h0e;
	localparam logic [5:0] SEL_ALL_OK = 6'h0f;
	localparam logic [5:0] SEL_DYN_BASE = 6'h10;
	localparam logic [5:0] SEL_LAST_VALID = 6'h17;
	localparam int MON_DIV_HALF = 4;
endpackage : spm_pkg

//--- verilog/spm_toggle_div.sv
`timescale 1ns/10ps
`default_nettype none
module spm_toggle_div (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic hold,
	input wire logic din,
	output logic dout
);
	logic prev;
	always_ff @(posedge sys_clk) begin
		if (!rst_n || hold) begin
			prev <= 1'b0;
			dout <= 1'b0;
		end else begin
			prev <= din;
			if (din && !prev) begin
				dout <= ~dout;
			end
		end
	end
endmodule : spm_toggle_div
`default_nettype wire

//--- verilog/spm_rate_div.sv
`timescale 1ns/10ps
`default_nettype none
module spm_rate_div #(
	parameter int HALF = 4
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic enable,
	input wire logic hold,
	input wire logic din,
	output logic dout
);
	// ----------------------------------------
	// Edge counting divider, output toggles every HALF rising edges
	// ----------------------------------------
	logic prev;
	logic [7:0] count;
	wire logic rise = din && !prev;
	wire logic wrap = (count == 8'(HALF - 1));
	always_ff @(posedge sys_clk) begin
		if (!rst_n || hold || !enable) begin
			prev <= 1'b0;
			count <= 8'h00;
			dout <= 1'b0;
		end else begin
			prev <= din;
			if (rise) begin
				count <= wrap ? 8'h00 : count + 8'h01;
				if (wrap) begin
					dout <= ~dout;
				end
			end
		end
	end
endmodule : spm_rate_div
`default_nettype wire

//--- verilog/spm_status_mux.sv
`timescale 1ns/10ps
`default_nettype none
module spm_status_mux (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [13:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic loopOneLocked,
	input wire logic loopTwoLocked,
	input wire logic referenceAOk,
	input wire logic referenceBOk,
	input wire logic testReferenceOk,
	input wire logic oscillatorOk,
	input wire logic loopOneFeedbackOk,
	input wire logic loopTwoReferenceOk,
	input wire logic referenceBSelected,
	input wire logic loopOneFeedbackClk,
	input wire logic loopOneDownPulse,
	input wire logic loopOneReferenceClk,
	input wire logic loopOneUpPulse,
	input wire logic loopTwoFeedbackClk,
	input wire logic loopTwoDownPulse,
	input wire logic loopTwoReferenceClk,
	input wire logic loopTwoUpPulse,
	input wire logic nvmTransferBusy,
	input wire logic syncPin_n,
	output logic dividerSyncHold,
	output logic monitorPinZero,
	output logic monitorPinOne
);
	import spm_pkg::*;

	// ----------------------------------------
	// Registers and APB slave
	// ----------------------------------------
	logic [7:0] monitorZeroSelect;
	logic [7:0] monitorOneSelect;
	logic [7:0] monitorPinControl;
	wire logic [11:0] regIndex = paddr[13:2];
	wire logic hitZero = (regIndex == MON_ZERO_SELECT_IDX);
	wire logic hitOne = (regIndex == MON_ONE_SELECT_IDX);
	wire logic hitCtl = (regIndex == MON_PIN_CONTROL_IDX);
	wire logic hitAny = hitZero || hitOne || hitCtl;
	wire logic accessPhase = psel && penable;
	wire logic writeStrobe = accessPhase && pwrite && hitAny && (paddr[1:0] == 2'b00);
	wire logic [7:0] readByte = hitZero ? monitorZeroSelect :
		hitOne ? monitorOneSelect :
		hitCtl ? monitorPinControl : 8'h00;

	// Zero-wait slave; unmapped or misaligned addresses answer with an error
	assign pready = 1'b1;
	assign pslverr = accessPhase && (!hitAny || (paddr[1:0] != 2'b00));

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			monitorZeroSelect <= SELECT_RESET;
			monitorOneSelect <= SELECT_RESET;
			monitorPinControl <= PIN_CONTROL_RESET;
		end else if (writeStrobe) begin
			if (hitZero) begin
				monitorZeroSelect <= {2'b00, pwdata[SEL_W-1:0]};
			end
			if (hitOne) begin
				monitorOneSelect <= {2'b00, pwdata[SEL_W-1:0]};
			end
			if (hitCtl) begin
				monitorPinControl <= pwdata[7:0] & CTL_WRITE_MASK;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			prdata <= 32'h0000_0000;
		end else if (psel && !penable && !pwrite) begin
			prdata <= {24'h00_0000, readByte};
		end
	end

	// ----------------------------------------
	// Divider hold
	// ----------------------------------------
	// Register bit acts like the sync pin pulled low
	wire logic ctlSync = monitorPinControl[CTL_SYNC_BIT];
	assign dividerSyncHold = ctlSync || !syncPin_n;

	// ----------------------------------------
	// Static status sources
	// ----------------------------------------
	wire logic bothRefsGone = !referenceAOk && !referenceBOk;
	wire logic [15:0] staticSrc = {
		// Clock flags only; lock states are not clocks and stay out of this term
		referenceAOk && referenceBOk && oscillatorOk && loopOneFeedbackOk && loopTwoReferenceOk,
		referenceAOk && referenceBOk,
		1'b0,
		loopTwoReferenceOk,
		loopOneFeedbackOk,
		oscillatorOk,
		testReferenceOk,
		referenceBOk,
		referenceAOk,
		referenceBSelected,
		bothRefsGone && loopTwoLocked,
		bothRefsGone,
		loopTwoLocked,
		loopOneLocked,
		loopOneLocked && loopTwoLocked,
		1'b0
	};

	// Halved dynamic sources: index 0-3 loop one, 4-7 loop two
	wire logic [7:0] dynRaw = {loopTwoUpPulse, loopTwoReferenceClk, loopTwoDownPulse, loopTwoFeedbackClk,
		loopOneUpPulse, loopOneReferenceClk, loopOneDownPulse, loopOneFeedbackClk};
	logic [7:0] dynHalf;
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++) begin : g_half
			spm_toggle_div u_half (
				.sys_clk(sys_clk),
				.rst_n(rst_n),
				.hold(dividerSyncHold),
				.din(dynRaw[gi]),
				.dout(dynHalf[gi])
			);
		end
	endgenerate

	// ----------------------------------------
	// Pin one selection
	// ----------------------------------------
	wire logic [5:0] selOne = monitorOneSelect[5:0];
	wire logic oneStatic = (selOne < SEL_DYN_BASE);
	wire logic oneDyn = (selOne >= 6'h14) && (selOne <= SEL_LAST_VALID);
	wire logic [1:0] oneDynIdx = selOne[1:0];
	// Codes 16-19 and above 23 fall to ground, as does 13 via the table
	wire logic muxOne = oneStatic ? staticSrc[selOne[3:0]] :
		oneDyn ? dynHalf[{1'b1, oneDynIdx}] : 1'b0;

	// ----------------------------------------
	// Pin zero selection
	// ----------------------------------------
	wire logic [5:0] selZero = monitorZeroSelect[5:0];
	wire logic zeroStatic = (selZero < SEL_DYN_BASE);
	wire logic zeroDyn = (selZero >= SEL_DYN_BASE) && (selZero < 6'h14);
	wire logic muxZero = zeroStatic ? staticSrc[selZero[3:0]] :
		zeroDyn ? dynHalf[{1'b0, selZero[1:0]}] : 1'b0;

	// ----------------------------------------
	// Optional rate dividers
	// ----------------------------------------
	// Static codes would just hold the divider still; software keeps them apart
	wire logic divOneOn = monitorPinControl[CTL_DIV1_BIT];
	wire logic divZeroOn = monitorPinControl[CTL_DIV0_BIT];
	logic divOneOut;
	logic divZeroOut;
	spm_rate_div #(.HALF(MON_DIV_HALF)) u_div_one (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.enable(divOneOn),
		.hold(dividerSyncHold),
		.din(muxOne),
		.dout(divOneOut)
	);
	spm_rate_div #(.HALF(MON_DIV_HALF)) u_div_zero (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.enable(divZeroOn),
		.hold(dividerSyncHold),
		.din(muxZero),
		.dout(divZeroOut)
	);

	wire logic nvmOnZero = monitorPinControl[CTL_NVM_BIT];
	wire logic next_pinOne = divOneOn ? divOneOut : muxOne;
	wire logic next_pinZero = nvmOnZero ? nvmTransferBusy :
		divZeroOn ? divZeroOut : muxZero;

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			monitorPinOne <= 1'b0;
			monitorPinZero <= 1'b0;
		end else begin
			monitorPinOne <= next_pinOne;
			monitorPinZero <= next_pinZero;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	chk_gnd_code: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(selOne == SEL_GND && !divOneOn) |=> !monitorPinOne)
		else $error("pin one not grounded for code zero");
	chk_lock_both: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(selOne == SEL_BOTH_LOCK && !divOneOn) |=> monitorPinOne == $past(loopOneLocked && loopTwoLocked))
		else $error("both-locked code wrong");
	chk_refs_gone: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(selOne == SEL_REFS_GONE_L2 && !divOneOn) |=> monitorPinOne == $past(bothRefsGone && loopTwoLocked))
		else $error("refs gone with lock wrong");
	chk_osc_ok: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(selOne == SEL_OSC_OK && !divOneOn) |=> monitorPinOne == $past(oscillatorOk))
		else $error("oscillator flag wrong");
	chk_reserved_low: assert property (@(posedge sys_clk) disable iff (!rst_n)
		((selOne == SEL_RESV13 || selOne > SEL_LAST_VALID) && !divOneOn) |=> !monitorPinOne)
		else $error("reserved code not low");
	chk_nvm_route: assert property (@(posedge sys_clk) disable iff (!rst_n)
		nvmOnZero |=> monitorPinZero == $past(nvmTransferBusy))
		else $error("nvm busy not routed");
	chk_sync_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(ctlSync && divOneOn) [*3] |-> !monitorPinOne)
		else $error("divider not held in sync");
	chk_upper_zero: assert property (@(posedge sys_clk) disable iff (!rst_n)
		monitorOneSelect[7:6] == 2'b00 && monitorZeroSelect[7:6] == 2'b00)
		else $error("reserved select bits set");
	chk_ground_band: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(selOne >= SEL_DYN_BASE && selOne < 6'h14 && !divOneOn) |=> !monitorPinOne)
		else $error("codes 16-19 not ground");
endmodule : spm_status_mux
`default_nettype wire

//--- verification/spm_pin_observer.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// Board-side observer of the monitor pins
// ----------------------------------------
module spm_pin_observer (
	input wire logic sys_clk,
	input wire logic clear,
	input wire logic monitorPinZero,
	input wire logic monitorPinOne,
	output int edgesZero,
	output int edgesOne
);
	logic lastZero = 1'b0;
	logic lastOne = 1'b0;
	// Counts every transition, so a halved clock shows one per source rising edge
	always @(posedge sys_clk) begin
		lastZero <= monitorPinZero;
		lastOne <= monitorPinOne;
		edgesZero <= clear ? 0 : edgesZero + int'(monitorPinZero !== lastZero);
		edgesOne <= clear ? 0 : edgesOne + int'(monitorPinOne !== lastOne);
	end
endmodule : spm_pin_observer
`default_nettype wire

//--- verification/spm_status_mux_tb.sv
`timescale 1ns/10ps
`default_nettype none
module spm_status_mux_tb;
	import spm_pkg::*;
	logic sys_clk, rst_n, psel, penable, pwrite, pready, pslverr, nvm, syncN, hold, pin0, pin1, clr, e;
	logic [13:0] paddr;
	logic [31:0] pwdata, prdata, r;
	logic [8:0] st;
	logic [7:0] dyn;
	logic [5:0] c, z;
	int e0, e1, errorCnt, nCompared;
	localparam logic [13:0] A0 = {MON_ZERO_SELECT_IDX, 2'b00};
	localparam logic [13:0] A1 = {MON_ONE_SELECT_IDX, 2'b00};
	localparam logic [13:0] AC = {MON_PIN_CONTROL_IDX, 2'b00};
	spm_status_mux dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.loopOneLocked(st[0]), .loopTwoLocked(st[1]), .referenceAOk(st[2]), .referenceBOk(st[3]),
		.testReferenceOk(st[4]), .oscillatorOk(st[5]), .loopOneFeedbackOk(st[6]), .loopTwoReferenceOk(st[7]),
		.referenceBSelected(st[8]), .loopOneFeedbackClk(dyn[0]), .loopOneDownPulse(dyn[1]),
		.loopOneReferenceClk(dyn[2]), .loopOneUpPulse(dyn[3]), .loopTwoFeedbackClk(dyn[4]),
		.loopTwoDownPulse(dyn[5]), .loopTwoReferenceClk(dyn[6]), .loopTwoUpPulse(dyn[7]),
		.nvmTransferBusy(nvm), .syncPin_n(syncN), .dividerSyncHold(hold), .monitorPinZero(pin0),
		.monitorPinOne(pin1));
	spm_pin_observer obs_u (.sys_clk(sys_clk), .clear(clr), .monitorPinZero(pin0), .monitorPinOne(pin1),
		.edgesZero(e0), .edgesOne(e1));
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic expPin(input logic [5:0] k, input logic [8:0] s);
		case (k)
			6'h01: return s[0] & s[1];
			6'h02: return s[0];
			6'h03: return s[1];
			6'h04: return ~s[2] & ~s[3];
			6'h05: return ~s[2] & ~s[3] & s[1];
			6'h06: return s[8];
			6'h07, 6'h08, 6'h09, 6'h0a, 6'h0b, 6'h0c: return s[k - 6'h05];
			6'h0e: return s[2] & s[3];
			6'h0f: return s[2] & s[3] & s[5] & s[6] & s[7];
			default: return 1'b0;
		endcase
	endfunction : expPin
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		nCompared++;
		if (got !== exp) begin
			errorCnt++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [13:0] a, input logic [31:0] d);
		int n;
		@(posedge sys_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		chk("pready", 32'h1, {31'h0, pready});
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic pulse(input int k, input int m);
		repeat (m) begin
			@(posedge sys_clk);
			dyn[k] <= 1'b1;
			dyn[k + 4] <= 1'b1;
			repeat (2) @(posedge sys_clk);
			dyn[k] <= 1'b0;
			dyn[k + 4] <= 1'b0;
			@(posedge sys_clk);
		end
		repeat (4) @(posedge sys_clk);
	endtask : pulse
	// Lead edges let a pin settle after a select change before counting restarts
	task automatic clear_counts;
		repeat (3) @(posedge sys_clk);
		clr <= 1'b1;
		@(posedge sys_clk);
		clr <= 1'b0;
	endtask : clear_counts
	task automatic tally_and_finish;
		$display("compared %0d mismatches %0d", nCompared, errorCnt);
		if (errorCnt == 0 && nCompared > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : tally_and_finish
	// ----------------------------------------
	// Stimulus
	// ----------------------------------------
	initial begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end
	initial begin
		repeat (20000) @(posedge sys_clk);
		errorCnt++;
		tally_and_finish;
	end
	initial begin
		{rst_n, psel, penable, pwrite, nvm, clr, paddr, pwdata, st, dyn} = '0;
		syncN = 1'b1;
		errorCnt = 0;
		nCompared = 0;
		void'($urandom(25));
		repeat (20) @(posedge sys_clk);
		rst_n <= 1'b1;
		for (int i = 0; i < 3; i++) begin
			apb(1'b0, i == 0 ? A0 : i == 1 ? A1 : AC, 32'h0);
			chk("reset value", 32'h0, r);
		end
		apb(1'b0, AC + 14'h4, 32'h0);
		chk("unmapped error", 32'h1, {31'h0, e});
		apb(1'b1, AC, 32'hff);
		apb(1'b0, AC, 32'h0);
		chk("control bits", {24'h0, CTL_WRITE_MASK}, r);
		chk("sync hold bit", 32'h1, {31'h0, hold});
		apb(1'b1, AC, 32'h10);
		for (int i = 0; i < 4; i++) begin
			nvm <= i[0];
			repeat (3) @(posedge sys_clk);
			chk("busy on pin zero", {31'h0, i[0]}, {31'h0, pin0});
		end
		apb(1'b1, AC, 32'h0);
		syncN <= 1'b0;
		repeat (2) @(posedge sys_clk);
		chk("sync pin hold", 32'h1, {31'h0, hold});
		syncN <= 1'b1;
		for (int i = 0; i < 40; i++) begin
			c = i < 20 ? 6'(i) : 6'($urandom_range(24, 63));
			z = (c < 6'h10 || c > SEL_LAST_VALID) ? c : 6'h14;
			st <= 9'($urandom);
			apb(1'b1, A1, {$urandom} & 32'hc0 | 32'(c));
			apb(1'b1, A0, 32'(z));
			apb(1'b0, A1, 32'h0);
			chk("select readback", 32'(c), r);
			repeat (3) @(posedge sys_clk);
			chk("pin one", {31'h0, expPin(c, st)}, {31'h0, pin1});
			chk("pin zero", {31'h0, expPin(z, st)}, {31'h0, pin0});
		end
		for (int k = 0; k < 4; k++) begin
			apb(1'b1, A1, 32'h14 + 32'(k));
			apb(1'b1, A0, 32'h10 + 32'(k));
			clear_counts();
			pulse(k, 10);
			chk("halved pin one", 32'd10, e1);
			chk("halved pin zero", 32'd10, e0);
		end
		apb(1'b1, AC, 32'h0c);
		clear_counts();
		pulse(3, 40);
		chk("pin one divider", 32'(40 / (2 * MON_DIV_HALF)), e1);
		chk("pin zero divider", 32'(40 / (2 * MON_DIV_HALF)), e0);
		apb(1'b1, AC, 32'h09);
		clear_counts();
		pulse(3, 10);
		chk("held divider", 32'h0, e1);
		tally_and_finish;
	end
endmodule : spm_status_mux_tb
`default_nettype wire
